/* logic/tpm_defines.svh */
// constants for the three-phase motor pwm block
`ifndef TPM_DEFINES_SVH
`define TPM_DEFINES_SVH
`define TPM_W            16
`define TPM_ZERO         16'h0000
`define TPM_ONE          16'h0001
`define TPM_MODE_W       4
`define TPM_MODE_RSYNC   4'h8
`define TPM_MODE_COMP    4'hD
`define TPM_CLR_W        3
`define TPM_CLR_PERIOD   3'h1
`define TPM_PSC_W        3
`define TPM_DIV_W        14
`define TPM_SEL_W        3
`define TPM_SEL_CH3      3'h0
`define TPM_SEL_CH4      3'h1
`define TPM_SEL_SUB      3'h2
`define TPM_SEL_PER      3'h3
`define TPM_SEL_CYC      3'h4
`define TPM_SEL_DT       3'h5
`define TPM_SEL_DUTY     3'h6
`define TPM_PHASES       3
`define TPM_POS_MASK     6'h0D
`define TPM_NEG_MASK     6'h32
`endif

/* logic/tpm_pkg.sv */
// types for the three-phase motor pwm block
`default_nettype none
package tpm_pkg;
   typedef enum logic [2:0] {
      TPM_IDLE  = 3'b001,
      TPM_RSYNC = 3'b010,
      TPM_COMP  = 3'b100
   } tpm_mode_t;
endpackage
`default_nettype wire

/* logic/tpm_prescale.sv */
// count-clock enable generator with prescaler and edge select
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defines.svh"
module tpm_prescale
   import tpm_pkg::*;
(
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  srst,
   // selection
   input  wire logic [`TPM_PSC_W-1:0] prescaler_select,
   input  wire logic                  clock_edge_sel_hi,
   input  wire logic                  clock_edge_sel_lo,
   // count enable
   output logic                       count_en
);
   logic [`TPM_DIV_W-1:0] div_reg;
   logic                  tap;
   logic                  tap_reg;
   logic                  rise;
   logic                  fall;
   logic                  pick;

   // divide by 2,4,16,64,... ; tap is a square wave of the chosen rate
   assign tap  = (prescaler_select == 3'h0) ? div_reg[0] :
                 div_reg[{prescaler_select[2:0], 1'b0} - 4'h1];
   assign rise = tap & ~tap_reg;
   assign fall = ~tap & tap_reg;
   assign pick = clock_edge_sel_hi ? (rise | fall) : (clock_edge_sel_lo ? fall : rise);

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         div_reg  <= '0;
         tap_reg  <= 1'b0;
         count_en <= 1'b0;
      end
      else
      begin
         div_reg  <= div_reg + `TPM_DIV_W'(1);
         tap_reg  <= tap;
         count_en <= pick;
      end
   end
endmodule
`default_nettype wire

/* logic/tpm_core.sv */
// three-phase motor pwm: reset-synchronized and complementary modes
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defines.svh"
module tpm_core
   import tpm_pkg::*;
(
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   srst,
   // register write port
   input  wire logic                   wr_en,
   input  wire logic [`TPM_SEL_W-1:0]  wr_sel,
   input  wire logic [1:0]             wr_phase,
   input  wire logic [`TPM_W-1:0]      wr_data,
   input  wire logic                   timer_access_enable,
   // buffer registers, always writable
   input  wire logic [`TPM_W-1:0]      period_buffer_reg,
   input  wire logic [`TPM_W-1:0]      cycle_buffer_reg,
   input  wire logic [`TPM_W-1:0]      phase1_duty_buffer,
   input  wire logic [`TPM_W-1:0]      phase2_duty_buffer,
   input  wire logic [`TPM_W-1:0]      phase3_duty_buffer,
   // control
   input  wire logic                   ch3_run_bit,
   input  wire logic                   ch4_run_bit,
   input  wire logic [`TPM_MODE_W-1:0] ch3_mode_field,
   input  wire logic [`TPM_CLR_W-1:0]  clear_source_select,
   input  wire logic [`TPM_PSC_W-1:0]  prescaler_select,
   input  wire logic                   clock_edge_sel_hi,
   input  wire logic                   clock_edge_sel_lo,
   input  wire logic                   period_toggle_enable,
   input  wire logic                   positive_level_select,
   input  wire logic                   negative_level_select,
   input  wire logic [5:0]             output_master_enable_reg,
   input  wire logic                   brushless_drive_enable,
   input  wire logic                   gate_direct_sel,
   input  wire logic [5:0]             gate_feedback_pattern,
   input  wire logic                   chop_clock,
   input  wire logic                   cutoff_pin,
   // readback
   input  wire logic [`TPM_SEL_W-1:0]  rd_sel,
   input  wire logic [1:0]             rd_phase,
   output logic [`TPM_W-1:0]           rd_data,
   // pins: {4d,4c,4b,4a,3d,3b}
   output logic [5:0]                  pwm_out,
   output logic [5:0]                  pwm_oe,
   output logic                        ch3_pin_a,
   output logic                        ch3_pin_a_oe
);
   tpm_mode_t           mode_reg;
   tpm_mode_t           mode_next;
   logic [`TPM_W-1:0]   ch3_counter, ch4_counter, deadtime_subcounter;
   logic [`TPM_W-1:0]   ch3_period_reg, cycle_data_reg, deadtime_reg;
   logic [`TPM_W-1:0]   duty_reg  [`TPM_PHASES];
   logic [`TPM_W-1:0]   temp_reg  [`TPM_PHASES];
   logic [`TPM_W-1:0]   dbuf      [`TPM_PHASES];
   logic                ch3_down_reg, ch4_down_reg;
   logic [2:0]          phase_reg;
   logic                toggle_reg;
   logic [2:0]          raw_pos, raw_neg;
   logic [1:0]          cut_sync_reg;
   logic [1:0]          chop_sync_reg;
   logic [5:0]          fb_sync1_reg, fb_sync2_reg;
   logic                count_en, run, acc;
   logic                per_match, rs_clear, comp_sel, rs_sel;
   logic                cy_top, cy_bot;
   logic [5:0]          raw_pins, gated, level_pins, pins_next, inact;

   assign dbuf[0] = phase1_duty_buffer;
   assign dbuf[1] = phase2_duty_buffer;
   assign dbuf[2] = phase3_duty_buffer;

   tpm_prescale u_prescale (
      .mclk              (mclk),
      .srst              (srst),
      .prescaler_select  (prescaler_select),
      .clock_edge_sel_hi (clock_edge_sel_hi),
      .clock_edge_sel_lo (clock_edge_sel_lo),
      .count_en          (count_en)
   );

   ////////////////////////////////////////////////////////////////////////
   // mode decode and counter control
   assign rs_sel    = (ch3_mode_field == `TPM_MODE_RSYNC);
   assign comp_sel  = (ch3_mode_field == `TPM_MODE_COMP);
   assign mode_next = comp_sel ? TPM_COMP : (rs_sel ? TPM_RSYNC : TPM_IDLE);
   assign run       = ch3_run_bit & ch4_run_bit & count_en;
   assign acc       = wr_en & timer_access_enable;
   assign per_match = (ch3_counter == ch3_period_reg);
   assign rs_clear  = per_match & (clear_source_select == `TPM_CLR_PERIOD);
   assign cy_top    = (ch4_counter == cycle_data_reg);
   assign cy_bot    = (ch4_counter == `TPM_ZERO);

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         mode_reg            <= TPM_IDLE;
         ch3_counter         <= `TPM_ZERO;
         ch4_counter         <= `TPM_ZERO;
         deadtime_subcounter <= `TPM_ZERO;
         ch3_down_reg        <= 1'b0;
         ch4_down_reg        <= 1'b0;
         ch3_period_reg      <= `TPM_ZERO;
         cycle_data_reg      <= `TPM_ZERO;
         deadtime_reg        <= `TPM_ZERO;
      end
      else
      begin
         mode_reg <= mode_next;
         if (mode_next == TPM_COMP && mode_reg != TPM_COMP)
         begin
            ch3_period_reg <= period_buffer_reg;
            cycle_data_reg <= cycle_buffer_reg;
            ch3_counter    <= deadtime_reg;
            ch4_counter    <= `TPM_ZERO;
            ch3_down_reg   <= 1'b0;
            ch4_down_reg   <= 1'b0;
         end
         else if (acc && wr_sel == `TPM_SEL_CH3)
            ch3_counter <= wr_data;
         else if (acc && wr_sel == `TPM_SEL_CH4)
            ch4_counter <= wr_data;
         else if (run && mode_reg == TPM_RSYNC)
         begin
            ch3_counter <= rs_clear ? `TPM_ZERO : ch3_counter + `TPM_ONE;
            ch4_counter <= rs_clear ? `TPM_ZERO : ch4_counter + `TPM_ONE;
         end
         else if (run && mode_reg == TPM_COMP)
         begin
            // bounce between deadtime and period, zero and cycle
            if (!ch3_down_reg && per_match)
               ch3_down_reg <= 1'b1;
            else if (ch3_down_reg && ch3_counter == deadtime_reg)
               ch3_down_reg <= 1'b0;
            ch3_counter <= (ch3_down_reg ? (ch3_counter == deadtime_reg) : !per_match) ?
                           ch3_counter + `TPM_ONE : ch3_counter - `TPM_ONE;
            if (!ch4_down_reg && cy_top)
               ch4_down_reg <= 1'b1;
            else if (ch4_down_reg && cy_bot)
               ch4_down_reg <= 1'b0;
            ch4_counter <= (ch4_down_reg ? cy_bot : !cy_top) ?
                           ch4_counter + `TPM_ONE : ch4_counter - `TPM_ONE;
            deadtime_subcounter <= ch4_down_reg ? ch4_counter : ch3_counter;
            // cycle update at the trough
            if (ch4_down_reg && cy_bot)
            begin
               ch3_period_reg <= period_buffer_reg;
               cycle_data_reg <= cycle_buffer_reg;
            end
         end
         if (acc && wr_sel == `TPM_SEL_PER)
            ch3_period_reg <= wr_data;
         if (acc && wr_sel == `TPM_SEL_CYC)
            cycle_data_reg <= wr_data;
         if (acc && wr_sel == `TPM_SEL_DT)
            deadtime_reg <= wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-phase duty, temporary register and waveform
   genvar g;
   generate
      for (g = 0; g < `TPM_PHASES; g++)
      begin : g_phase
         logic hit;
         assign hit = (ch3_counter == duty_reg[g]);
         always_ff @(posedge mclk)
         begin
            if (srst)
            begin
               duty_reg[g]  <= `TPM_ZERO;
               temp_reg[g]  <= `TPM_ZERO;
               phase_reg[g] <= 1'b0;
            end
            else
            begin
               if (!ch4_down_reg)
                  temp_reg[g] <= dbuf[g];
               if (mode_next == TPM_COMP && mode_reg != TPM_COMP)
                  duty_reg[g] <= dbuf[g];
               else if (acc && wr_sel == `TPM_SEL_DUTY && wr_phase == 2'(g))
                  duty_reg[g] <= wr_data;
               else if (run && mode_reg == TPM_COMP && ch4_down_reg && cy_bot)
                  duty_reg[g] <= temp_reg[g];
               if (run && mode_reg == TPM_RSYNC && (hit || rs_clear))
                  phase_reg[g] <= ~phase_reg[g];
               else if (run && mode_reg == TPM_COMP && hit)
                  phase_reg[g] <= ~ch3_down_reg;
               else if (mode_reg == TPM_IDLE)
                  phase_reg[g] <= 1'b0;
            end
         end
         assign raw_pos[g] = phase_reg[g] & !(mode_reg == TPM_COMP && ch4_down_reg && ch3_counter < deadtime_reg);
         assign raw_neg[g] = ~phase_reg[g] & (mode_reg != TPM_IDLE);
      end
   endgenerate

   // pin order {4d,4c,4b,4a,3d,3b}: negatives of phases 1..3 sit on 3d, 4c, 4d
   assign raw_pins = {raw_neg[2], raw_neg[1], raw_pos[2], raw_pos[1], raw_neg[0], raw_pos[0]};

   ////////////////////////////////////////////////////////////////////////
   // brushless gating, cutoff, levels, enables
   assign gated = !brushless_drive_enable ? raw_pins :
                  (gate_direct_sel ? fb_sync2_reg : (fb_sync2_reg & {6{chop_sync_reg[1]}}));
   assign inact      = (`TPM_POS_MASK & {6{~positive_level_select}}) |
                       (`TPM_NEG_MASK & {6{~negative_level_select}});
   assign level_pins = gated ^ inact;
   assign pins_next  = (cut_sync_reg[1] || mode_reg == TPM_IDLE) ? inact : level_pins;

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         cut_sync_reg  <= 2'h0;
         chop_sync_reg <= 2'h0;
         fb_sync1_reg  <= 6'h00;
         fb_sync2_reg  <= 6'h00;
         pwm_out       <= 6'h00;
         pwm_oe        <= 6'h00;
         toggle_reg    <= 1'b0;
         ch3_pin_a     <= 1'b0;
         ch3_pin_a_oe  <= 1'b0;
         rd_data       <= `TPM_ZERO;
      end
      else
      begin
         cut_sync_reg  <= {cut_sync_reg[0], cutoff_pin};
         chop_sync_reg <= {chop_sync_reg[0], chop_clock};
         fb_sync1_reg  <= gate_feedback_pattern;
         fb_sync2_reg  <= fb_sync1_reg;
         pwm_out       <= pins_next;
         pwm_oe        <= (mode_reg != TPM_IDLE) ? output_master_enable_reg : 6'h00;
         if (run && mode_reg == TPM_COMP && ((!ch3_down_reg && per_match) || (ch4_down_reg && cy_bot)))
            toggle_reg <= ~toggle_reg;
         ch3_pin_a     <= toggle_reg;
         ch3_pin_a_oe  <= (mode_reg == TPM_COMP) && period_toggle_enable;
         unique case (rd_sel)
            `TPM_SEL_CH3:  rd_data <= timer_access_enable ? ch3_counter : `TPM_ZERO;
            `TPM_SEL_CH4:  rd_data <= timer_access_enable ? ch4_counter : `TPM_ZERO;
            `TPM_SEL_SUB:  rd_data <= deadtime_subcounter;
            `TPM_SEL_PER:  rd_data <= timer_access_enable ? ch3_period_reg : `TPM_ZERO;
            `TPM_SEL_CYC:  rd_data <= timer_access_enable ? cycle_data_reg : `TPM_ZERO;
            `TPM_SEL_DT:   rd_data <= timer_access_enable ? deadtime_reg : `TPM_ZERO;
            `TPM_SEL_DUTY: rd_data <= (timer_access_enable && rd_phase != 2'h3) ?
                                      duty_reg[rd_phase] : `TPM_ZERO;
            default:       rd_data <= `TPM_ZERO;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   assert_mode_decode_a: assert property (@(posedge mclk) disable iff (srst)
      (ch3_mode_field == `TPM_MODE_RSYNC) |=> (mode_reg == TPM_RSYNC))
      else $error("reset-sync mode not selected");
   rs_clear_zero_a: assert property (@(posedge mclk) disable iff (srst)
      (run && mode_reg == TPM_RSYNC && rs_clear && !acc && mode_next == TPM_RSYNC) |=> (ch3_counter == `TPM_ZERO))
      else $error("counter not cleared on period match");
   rs_toggle_a: assert property (@(posedge mclk) disable iff (srst)
      (run && mode_reg == TPM_RSYNC && rs_clear) |=> (phase_reg[0] != $past(phase_reg[0])))
      else $error("output not toggled on clear");
   access_gate_a: assert property (@(posedge mclk) disable iff (srst)
      (wr_en && !timer_access_enable && wr_sel == `TPM_SEL_DT) |=> $stable(deadtime_reg))
      else $error("write passed while access disabled");
   cutoff_force_a: assert property (@(posedge mclk) disable iff (srst)
      cut_sync_reg[1] |=> (pwm_out[0] == $past(~positive_level_select)))
      else $error("cutoff not forcing inactive");
   oe_gate_a: assert property (@(posedge mclk) disable iff (srst)
      (mode_reg != TPM_IDLE) |=> (pwm_oe == $past(output_master_enable_reg)))
      else $error("pin enable mismatch");
   toggle_oe_a: assert property (@(posedge mclk) disable iff (srst)
      (mode_reg == TPM_COMP && !period_toggle_enable) |=> !ch3_pin_a_oe)
      else $error("toggle pin driven while disabled");
   comp_load_a: assert property (@(posedge mclk) disable iff (srst)
      (mode_next == TPM_COMP && mode_reg != TPM_COMP && !acc) |=> (ch3_counter == $past(deadtime_reg)))
      else $error("complementary start not at deadtime");
   ch4_bounce_a: assert property (@(posedge mclk) disable iff (srst)
      (run && mode_reg == TPM_COMP && !ch4_down_reg && cy_top && !acc && mode_next == TPM_COMP)
      |=> ch4_down_reg)
      else $error("channel 4 did not turn at cycle top");
endmodule
`default_nettype wire

/* dv/tpm_gate_model.sv */
// gate driver model for the three inverter legs fed by the pwm pins
`timescale 1ns/1ps
`default_nettype none
module tpm_gate_model
(
   // clock and monitor clear
   input  wire logic       mclk,
   input  wire logic       clr,
   // pins from the pwm block, order {4d,4c,4b,4a,3d,3b}
   input  wire logic [5:0] pwm_out,
   input  wire logic [5:0] pwm_oe,
   input  wire logic       pos_active,
   input  wire logic       neg_active,
   // gate state of the legs
   output logic [5:0]      gate_on,
   output logic [5:0]      seen_on,
   output var int          overlap_cnt
);
   logic [5:0] act;
   logic       shoot;
   // a released pin falls to the driver pull-down, so its gate is off
   assign act     = {neg_active, neg_active, pos_active, pos_active, neg_active, pos_active};
   assign gate_on = pwm_oe & ~(pwm_out ^ act);
   // upper and lower switch of one leg on together shorts the supply
   assign shoot   = (gate_on[0] & gate_on[1]) | (gate_on[2] & gate_on[4]) | (gate_on[3] & gate_on[5]);
   always @(posedge mclk)
   begin
      seen_on <= clr ? 6'h00 : (seen_on | gate_on);
      overlap_cnt <= clr ? 0 : overlap_cnt + int'(shoot === 1'b1);
   end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the three-phase motor pwm block
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defines.svh"
module tb_top;
   import tpm_pkg::*;
   ////////////////////////////////////////////////////////////
   // design inputs
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic        wr_en = 1'b0;
   logic [2:0]  wr_sel = 3'h0;
   logic [1:0]  wr_phase = 2'h0;
   logic [15:0] wr_data = 16'h0000;
   logic        timer_access_enable = 1'b1;
   logic [15:0] period_buffer_reg = 16'h0000;
   logic [15:0] cycle_buffer_reg = 16'h0000;
   logic [15:0] phase1_duty_buffer = 16'h0000;
   logic [15:0] phase2_duty_buffer = 16'h0000;
   logic [15:0] phase3_duty_buffer = 16'h0000;
   logic        ch3_run_bit = 1'b0;
   logic        ch4_run_bit = 1'b0;
   logic [3:0]  ch3_mode_field = 4'h0;
   logic [2:0]  clear_source_select = 3'h0;
   logic [2:0]  prescaler_select = 3'h0;
   logic        clock_edge_sel_hi = 1'b0;
   logic        clock_edge_sel_lo = 1'b0;
   logic        brushless_drive_enable = 1'b0;
   logic        gate_direct_sel = 1'b0;
   logic [5:0]  gate_feedback_pattern = 6'h00;
   logic        period_toggle_enable = 1'b0;
   logic        positive_level_select = 1'b1;
   logic        negative_level_select = 1'b1;
   logic [5:0]  output_master_enable_reg = 6'h3F;
   logic        chop_clock = 1'b0;
   logic        cutoff_pin = 1'b0;
   logic [2:0]  rd_sel = 3'h0;
   logic [1:0]  rd_phase = 2'h0;
   // outputs, gate state and bookkeeping
   logic [15:0] rd_data;
   logic [5:0]  pwm_out, pwm_oe, gate_on, seen_on;
   logic        ch3_pin_a, ch3_pin_a_oe;
   logic        gclr = 1'b0;
   logic [15:0] mx, mn;
   int          ovl, wraps, tg0, tg3, tga, cmp_err;
   int          n_mismatch = 0;
   int          checks = 0;
   int          cyc = 0;
   logic [2:0]  tsel [8] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6, 3'h6};
   logic [1:0]  tph [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
   ////////////////////////////////////////////////////////////
   // channel 3 C stays a plain port; channel 4 also restarts by sync clear
   tpm_core u_tpm_core
   (
      .mclk, .srst, .wr_en, .wr_sel, .wr_phase, .wr_data, .timer_access_enable,
      .period_buffer_reg, .cycle_buffer_reg, .phase1_duty_buffer, .phase2_duty_buffer,
      .phase3_duty_buffer, .ch3_run_bit, .ch4_run_bit, .ch3_mode_field, .clear_source_select,
      .prescaler_select, .clock_edge_sel_hi, .clock_edge_sel_lo, .period_toggle_enable,
      .positive_level_select, .negative_level_select, .output_master_enable_reg,
      .brushless_drive_enable, .gate_direct_sel, .gate_feedback_pattern,
      .chop_clock, .cutoff_pin, .rd_sel, .rd_phase, .rd_data, .pwm_out, .pwm_oe, .ch3_pin_a,
      .ch3_pin_a_oe
   );
   tpm_gate_model u_tpm_gate_model
   (
      .mclk, .clr(gclr | srst), .pwm_out, .pwm_oe, .pos_active(positive_level_select),
      .neg_active(negative_level_select), .gate_on, .seen_on, .overlap_cnt(ovl)
   );
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) chop_clock <= ~chop_clock;
   ////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] s, input logic [1:0] p, input logic [15:0] d);
      @(posedge mclk);
      wr_en <= 1'b1;
      wr_sel <= s;
      wr_phase <= p;
      wr_data <= d;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] s, input logic [1:0] p, input logic [15:0] e);
      @(posedge mclk);
      rd_sel <= s;
      rd_phase <= p;
      repeat (2) @(posedge mclk);
      #1 chk("rd_data", e, rd_data);
   endtask
   // halt, load counters and compares, select the mode, start both counters on one edge
   task automatic setup(input logic [3:0] m, input logic [2:0] cs, input logic pl, input logic pt,
                        input logic [15:0] c3, input logic [15:0] per, input logic [15:0] cy,
                        input logic [15:0] dt, input logic [15:0] d1, input logic [15:0] d2,
                        input logic [15:0] d3);
      @(posedge mclk);
      ch3_run_bit <= 1'b0;
      ch4_run_bit <= 1'b0;
      ch3_mode_field <= 4'h0;
      clear_source_select <= cs;
      wr(`TPM_SEL_CH3, 2'h0, c3);
      wr(`TPM_SEL_CH4, 2'h0, 16'h0000);
      wr(`TPM_SEL_PER, 2'h0, per);
      wr(`TPM_SEL_CYC, 2'h0, cy);
      wr(`TPM_SEL_DT, 2'h0, dt);
      wr(`TPM_SEL_DUTY, 2'h0, d1);
      wr(`TPM_SEL_DUTY, 2'h1, d2);
      wr(`TPM_SEL_DUTY, 2'h2, d3);
      period_buffer_reg <= per;
      cycle_buffer_reg <= cy;
      phase1_duty_buffer <= d1;
      phase2_duty_buffer <= d2;
      phase3_duty_buffer <= d3;
      positive_level_select <= pl;
      period_toggle_enable <= pt;
      output_master_enable_reg <= 6'h3F;
      @(posedge mclk);
      ch3_mode_field <= m;
      @(posedge mclk);
      ch3_run_bit <= 1'b1;
      ch4_run_bit <= 1'b1;
      @(posedge mclk);
      gclr <= 1'b1;
      @(posedge mclk);
      gclr <= 1'b0;
   endtask
   // streams one counter and tallies its range, clears and pin toggles
   task automatic watch(input logic [2:0] s, input int n);
      logic [15:0] prv;
      logic [5:0]  po;
      logic        pa;
      @(posedge mclk);
      rd_sel <= s;
      repeat (3) @(posedge mclk);
      #1;
      mx = rd_data;
      mn = rd_data;
      prv = rd_data;
      po = pwm_out;
      pa = ch3_pin_a;
      {wraps, tg0, tg3, tga, cmp_err} = '0;
      repeat (n)
      begin
         @(posedge mclk);
         #1;
         if (rd_data > mx) mx = rd_data;
         if (rd_data < mn) mn = rd_data;
         if (rd_data == 16'h0000 && prv != 16'h0000) wraps++;
         if (pwm_out[0] !== po[0]) tg0++;
         if (pwm_out[3] !== po[3]) tg3++;
         if (ch3_pin_a !== pa) tga++;
         if (pwm_out[1] === pwm_out[0] || pwm_out[4] === pwm_out[2] || pwm_out[5] === pwm_out[3]) cmp_err++;
         prv = rd_data;
         po = pwm_out;
         pa = ch3_pin_a;
      end
   endtask
   ////////////////////////////////////////////////////////////
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 8000)
      begin
         n_mismatch++;
         conclude();
      end
   end
   initial
   begin
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      #1 chk("pwm_oe", 16'h0000, 16'(pwm_oe));
      chk("pwm_out", 16'h0000, 16'(pwm_out));
      @(posedge mclk);
      timer_access_enable <= 1'b0;
      wr(`TPM_SEL_DT, 2'h0, 16'h0007);
      rd(`TPM_SEL_DT, 2'h0, 16'h0000);
      @(posedge mclk);
      timer_access_enable <= 1'b1;
      rd(`TPM_SEL_DT, 2'h0, 16'h0000);
      foreach (tsel[i]) wr(tsel[i], tph[i], 16'hA5A0 + 16'(i));
      foreach (tsel[i]) rd(tsel[i], tph[i], 16'hA5A0 + 16'(i));
      wr(`TPM_SEL_SUB, 2'h0, 16'h1234);
      rd(`TPM_SEL_SUB, 2'h0, 16'h0000);
      @(posedge mclk);
      timer_access_enable <= 1'b0;
      rd(`TPM_SEL_CH3, 2'h0, 16'h0000);
      @(posedge mclk);
      timer_access_enable <= 1'b1;
      // reset-synchronized: period 20, phase 3 transition equal to the period
      setup(`TPM_MODE_RSYNC, `TPM_CLR_PERIOD, 1'b1, 1'b0, 16'h0000, 16'h0014, 16'h0000, 16'h0000,
            16'h0005, 16'h000A, 16'h0014);
      watch(`TPM_SEL_CH3, 600);
      chk("ch3 max", 16'h0014, mx);
      chk("ch3 min", 16'h0000, mn);
      chk("ph1 toggles", 16'h0001, 16'(tg0 >= 2 * wraps - 2 && tg0 <= 2 * wraps + 2 && wraps > 4));
      chk("ph3 toggles", 16'h0001, 16'(tg3 >= wraps - 1 && tg3 <= wraps + 1 && wraps > 4));
      chk("neg phases", 16'h0000, 16'(cmp_err));
      chk("pwm_oe", 16'h003F, 16'(pwm_oe));
      @(posedge mclk);
      output_master_enable_reg <= 6'h05;
      repeat (3) @(posedge mclk);
      #1 chk("pwm_oe", 16'h0005, 16'(pwm_oe));
      // complementary: dead time 4, half carrier 20, both polarities of the positive phases
      for (int k = 0; k < 3; k++)
      begin
         @(posedge mclk);
         prescaler_select <= 3'(k != 0);
         clock_edge_sel_lo <= 1'(k == 1);
         clock_edge_sel_hi <= 1'(k == 2);
         negative_level_select <= 1'(k != 2);
         setup(`TPM_MODE_COMP, 3'h0, 1'(k != 1), 1'b1, 16'h0004, 16'h0018, 16'h0014, 16'h0004,
               16'h000A, 16'h0008, 16'h000C);
         watch(`TPM_SEL_CH3, 400);
         chk("ch3 max", 16'h0018, mx);
         chk("ch3 min", 16'h0004, mn);
         chk("overlap", 16'h0000, 16'(ovl));
         chk("gates seen", 16'h003F, 16'(seen_on));
         chk("pin a oe", 16'h0001, 16'(ch3_pin_a_oe));
         chk("pin a toggles", 16'h0001, 16'(tga > 1));
         watch(`TPM_SEL_CH4, 400);
         chk("ch4 max", 16'h0014, mx);
         chk("ch4 min", 16'h0000, mn);
         chk("ch4 rate", 16'h0001, 16'(k == 1 ? (wraps >= 2 && wraps <= 3) : (wraps >= 4 && wraps <= 5)));
      end
      @(posedge mclk);
      cutoff_pin <= 1'b1;
      repeat (5) @(posedge mclk);
      #1 chk("gates cut", 16'h0000, 16'(gate_on));
      @(posedge mclk);
      cutoff_pin <= 1'b0;
      period_toggle_enable <= 1'b0;
      repeat (3) @(posedge mclk);
      #1 chk("pin a oe", 16'h0000, 16'(ch3_pin_a_oe));
      @(posedge mclk);
      brushless_drive_enable <= 1'b1;
      gate_direct_sel <= 1'b1;
      gate_feedback_pattern <= 6'h25;
      repeat (5) @(posedge mclk);
      #1 chk("gates direct", 16'h0025, 16'(gate_on));
      @(posedge mclk);
      gate_direct_sel <= 1'b0;
      repeat (5) @(posedge mclk);
      #1 mx = 16'(gate_on);
      @(posedge mclk);
      #1 mn = 16'(gate_on);
      chk("gates chopped", 16'h0025, mx | mn);
      chk("chop gaps", 16'h0000, mx & mn);
      conclude();
   end
endmodule
`default_nettype wire
